//--- core/lvc_pkg.sv
// package for the linear regulator enable / voltage control block
// assumes a 32-bit apb register bus and a 100 MHz pclk
package lvc_pkg;
    // register byte offsets
    localparam logic [11:0] LVC_OFS_CTRL = 12'h000;
    localparam logic [11:0] LVC_OFS_VOLT = 12'h004;
    localparam logic [11:0] LVC_OFS_STAT = 12'h008;
    localparam logic [11:0] LVC_OFS_MVOLT = 12'h00c;
    // ctrl fields
    localparam int LVC_CTRL_RUN_EN_BIT = 0;
    localparam int LVC_CTRL_STBY_EN_BIT = 1;
    // volt fields
    localparam int LVC_VOLT_RUN_LSB = 0;
    localparam int LVC_VOLT_STBY_LSB = 4;
    localparam int LVC_VSET_W = 4;
    // stat fields
    localparam int LVC_STAT_EN_BIT = 0;
    localparam int LVC_STAT_PD_BIT = 1;
    localparam int LVC_STAT_SW_BIT = 2;
    localparam int LVC_STAT_STBY_BIT = 3;
    localparam int LVC_STAT_VSET_LSB = 4;
    localparam int LVC_STAT_MODE_LSB = 8;
    // reset values
    localparam logic LVC_EN_RST = 1'b0;
    localparam logic [3:0] LVC_VSET_RST = 4'h0;
    // setpoint output in millivolts, codes 0..15
    localparam int LVC_MV_W = 13;
    // operating modes
    typedef enum logic [1:0] {
        LVC_MODE_OFF,
        LVC_MODE_NORMAL,
        LVC_MODE_SWITCH
    } lvc_mode_t;
endpackage

//--- core/lvc_vset_rom.sv
// setpoint code to output millivolt lookup, registered output
// assumes pclk / presetn from the parent block
`timescale 1ns/1ps
module lvc_vset_rom
    import lvc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // lookup
    input wire logic [LVC_VSET_W-1:0] code,
    output logic [LVC_MV_W-1:0] mv_ff
);
    logic [LVC_MV_W-1:0] nxt_mv;

    always_comb begin
        case (code) // [R7]
            4'h0: nxt_mv = 13'd1500;
            4'h1: nxt_mv = 13'd1600;
            4'h2: nxt_mv = 13'd1800;
            4'h3: nxt_mv = 13'd1850;
            4'h4: nxt_mv = 13'd2150;
            4'h5: nxt_mv = 13'd2500;
            4'h6: nxt_mv = 13'd2800;
            4'h7: nxt_mv = 13'd3000;
            4'h8: nxt_mv = 13'd3100;
            4'h9: nxt_mv = 13'd3150;
            4'ha: nxt_mv = 13'd3200;
            4'hb: nxt_mv = 13'd3300;
            4'hc: nxt_mv = 13'd3350;
            4'hd: nxt_mv = 13'd4000;
            4'he: nxt_mv = 13'd4900;
            default: nxt_mv = 13'd5000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mv_ff <= 13'd1500;
        end else begin
            mv_ff <= nxt_mv;
        end
    end
endmodule

//--- core/lvc_ctrl.sv
// linear regulator enable, mode and setpoint control with apb registers
// assumes nvm values and sequencer inputs are stable and synchronous to pclk
`timescale 1ns/1ps
// Overview of operation
// (R1) active enable is run bit in run, standby bit in standby
// (R2) sequencer sets enable bits when regulator is in sequence, else 0
// (R3) enable 0 gives disabled with pull-down; enable 1 picks mode by mode bit
// (R4) normal versus switch comes from nvm mode bit, not a writable field
// (R5) separate run and standby setpoints; the active state's one is applied
// (R6) at power up both setpoints load the nvm setpoint value
// (R7) setpoint codes 0..15 map to 1.5 V up to 5.0 V
// (R8) mode bit 1 makes the regulator a pass-through input to output switch
// (R9) in switch operation the switch follows the enable bit
// (R10) run/standby changes re-select enable and setpoint without software
module lvc_ctrl
    import lvc_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system state and power-up sequencer
    input wire logic standby_state,
    input wire logic pwrup_load,
    input wire logic pwrup_in_seq,
    // one-time-programmable configuration
    input wire logic nvm_switch_mode_sel,
    input wire logic [LVC_VSET_W-1:0] nvm_voltage_setpoint,
    // regulator control
    output logic reg_enable,
    output logic reg_pulldown,
    output logic switch_enable,
    output logic [LVC_VSET_W-1:0] voltage_setpoint,
    output logic [LVC_MV_W-1:0] voltage_mv
);
    logic reg_run_enable_ff;
    logic reg_standby_enable_ff;
    logic [LVC_VSET_W-1:0] run_voltage_setpoint_ff;
    logic [LVC_VSET_W-1:0] standby_voltage_setpoint_ff;
    logic switch_mode_sel_ff;
    logic reg_enable_ff;
    logic reg_pulldown_ff;
    logic switch_enable_ff;
    logic standby_ff;
    logic [LVC_VSET_W-1:0] vset_ff;
    lvc_mode_t mode_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic wr_acc;
    logic rd_acc;
    logic addr_ok;
    logic nxt_en;
    logic [LVC_VSET_W-1:0] nxt_vset;
    lvc_mode_t nxt_mode;
    logic [31:0] nxt_rdata;
    logic [LVC_MV_W-1:0] mv;

    // single-wait-state apb: answer one cycle after the access phase begins
    assign addr_ok = (paddr == LVC_OFS_CTRL) || (paddr == LVC_OFS_VOLT) ||
                     (paddr == LVC_OFS_STAT) || (paddr == LVC_OFS_MVOLT);
    assign wr_acc = psel && penable && pwrite && pready_ff && addr_ok;
    assign rd_acc = psel && penable && !pwrite && !pready_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_ok;
        end
    end

    // enable bits: sequencer load wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reg_run_enable_ff <= LVC_EN_RST;
            reg_standby_enable_ff <= LVC_EN_RST;
        end else if (pwrup_load) begin
            reg_run_enable_ff <= pwrup_in_seq; // [R2]
            reg_standby_enable_ff <= pwrup_in_seq; // [R2]
        end else if (wr_acc && paddr == LVC_OFS_CTRL && pstrb[0]) begin
            reg_run_enable_ff <= pwdata[LVC_CTRL_RUN_EN_BIT];
            reg_standby_enable_ff <= pwdata[LVC_CTRL_STBY_EN_BIT];
        end
    end

    // setpoints
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_voltage_setpoint_ff <= LVC_VSET_RST;
            standby_voltage_setpoint_ff <= LVC_VSET_RST;
        end else if (pwrup_load) begin
            run_voltage_setpoint_ff <= nvm_voltage_setpoint; // [R6]
            standby_voltage_setpoint_ff <= nvm_voltage_setpoint; // [R6]
        end else if (wr_acc && paddr == LVC_OFS_VOLT && pstrb[0]) begin
            run_voltage_setpoint_ff <= pwdata[LVC_VOLT_RUN_LSB +: LVC_VSET_W];
            standby_voltage_setpoint_ff <= pwdata[LVC_VOLT_STBY_LSB +: LVC_VSET_W];
        end
    end

    // mode bit has no write path; resampled from nvm on every clock after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_mode_sel_ff <= 1'b0;
        end else begin
            switch_mode_sel_ff <= nvm_switch_mode_sel; // [R4]
        end
    end

    // selection is purely from current state, so a run/standby flip needs no write
    always_comb begin
        nxt_en = standby_state ? reg_standby_enable_ff : reg_run_enable_ff; // [R1] [R10]
        nxt_vset = standby_state ? standby_voltage_setpoint_ff : run_voltage_setpoint_ff; // [R5] [R10]
        case ({nxt_en, switch_mode_sel_ff}) // [R3]
            2'b10: nxt_mode = LVC_MODE_NORMAL;
            2'b11: nxt_mode = LVC_MODE_SWITCH; // [R8]
            default: nxt_mode = LVC_MODE_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= LVC_MODE_OFF;
            standby_ff <= 1'b0;
            vset_ff <= LVC_VSET_RST;
            reg_enable_ff <= 1'b0;
            reg_pulldown_ff <= 1'b1;
            switch_enable_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            standby_ff <= standby_state;
            vset_ff <= nxt_vset; // [R5]
            reg_enable_ff <= (nxt_mode == LVC_MODE_NORMAL);
            reg_pulldown_ff <= (nxt_mode == LVC_MODE_OFF); // [R3]
            switch_enable_ff <= (nxt_mode == LVC_MODE_SWITCH); // [R8] [R9]
        end
    end

    lvc_vset_rom u_rom (
        .pclk(pclk),
        .presetn(presetn),
        .code(vset_ff),
        .mv_ff(mv)
    );

    // read mux
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        case (paddr)
            LVC_OFS_CTRL: begin
                nxt_rdata[LVC_CTRL_RUN_EN_BIT] = reg_run_enable_ff;
                nxt_rdata[LVC_CTRL_STBY_EN_BIT] = reg_standby_enable_ff;
            end
            LVC_OFS_VOLT: begin
                nxt_rdata[LVC_VOLT_RUN_LSB +: LVC_VSET_W] = run_voltage_setpoint_ff;
                nxt_rdata[LVC_VOLT_STBY_LSB +: LVC_VSET_W] = standby_voltage_setpoint_ff;
            end
            LVC_OFS_STAT: begin
                nxt_rdata[LVC_STAT_EN_BIT] = reg_enable_ff;
                nxt_rdata[LVC_STAT_PD_BIT] = reg_pulldown_ff;
                nxt_rdata[LVC_STAT_SW_BIT] = switch_enable_ff;
                nxt_rdata[LVC_STAT_STBY_BIT] = standby_ff;
                nxt_rdata[LVC_STAT_VSET_LSB +: LVC_VSET_W] = vset_ff;
                nxt_rdata[LVC_STAT_MODE_LSB +: 2] = mode_ff;
            end
            LVC_OFS_MVOLT: begin
                nxt_rdata[LVC_MV_W-1:0] = mv;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_acc) begin
            prdata_ff <= nxt_rdata;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign reg_enable = reg_enable_ff;
    assign reg_pulldown = reg_pulldown_ff;
    assign switch_enable = switch_enable_ff;
    assign voltage_setpoint = vset_ff;
    assign voltage_mv = mv;
endmodule

//--- bench/lvc_ctrl_properties.sv
// port relations of the regulator control block
// assumes binding onto lvc_ctrl, nvm inputs steady across reset
`timescale 1ns/1ps
module lvc_ctrl_chk
    import lvc_pkg::*;
(
    // clock, reset and bus
    input wire logic pclk, presetn, psel, penable, pready,
    // sequencer and nvm
    input wire logic pwrup_load, pwrup_in_seq, nvm_switch_mode_sel,
    input wire logic [LVC_VSET_W-1:0] nvm_voltage_setpoint,
    // regulator control
    input wire logic reg_enable, reg_pulldown, switch_enable,
    input wire logic [LVC_VSET_W-1:0] voltage_setpoint,
    input wire logic [LVC_MV_W-1:0] voltage_mv
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pd_excl_a: assert property (reg_pulldown |-> !reg_enable && !switch_enable)
        else $error("pull-down while output driven");
    one_state_a: assert property (reg_pulldown || reg_enable || switch_enable)
        else $error("no operating state");
    norm_sw_a: assert property (!(reg_enable && switch_enable))
        else $error("regulating and switching together");
    sw_mode_a: assert property (switch_enable |-> $past(nvm_switch_mode_sel, 2))
        else $error("switch closed without mode bit");
    norm_mode_a: assert property (reg_enable |-> !$past(nvm_switch_mode_sel, 2))
        else $error("regulating with switch mode bit");
    // a write landing right after the load may legally override it
    seq_off_a: assert property (pwrup_load && !pwrup_in_seq ##1 !(psel && penable && pready) && !pwrup_load
        |=> reg_pulldown)
        else $error("enable not cleared by load");
    vset_load_a: assert property (pwrup_load ##1 !(psel && penable && pready) && !pwrup_load
        |=> voltage_setpoint == $past(nvm_voltage_setpoint, 2))
        else $error("setpoint not loaded from nvm");
    mv_code_a: assert property (voltage_setpoint == 4'h3 |=> voltage_mv == 13'd1850)
        else $error("code 3 millivolts wrong");
endmodule
bind lvc_ctrl lvc_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pwrup_load(pwrup_load), .pwrup_in_seq(pwrup_in_seq),
    .nvm_switch_mode_sel(nvm_switch_mode_sel), .nvm_voltage_setpoint(nvm_voltage_setpoint),
    .reg_enable(reg_enable), .reg_pulldown(reg_pulldown), .switch_enable(switch_enable),
    .voltage_setpoint(voltage_setpoint), .voltage_mv(voltage_mv));

//--- bench/tb.sv
// self-checking bench for lvc_ctrl over apb
// assumes one wait state apb slave, outputs settle within two edges
`timescale 1ns/1ps
module tb
    import lvc_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, stby = 0, load = 0, in_seq = 1, nvm_sw = 0;
    logic [3:0] nvm_v = 4'h7, vset;
    logic reg_enable, reg_pulldown, switch_enable;
    logic [12:0] mv;
    int failures = 0, n_tests = 0;
    int mv_tbl [16] = '{1500, 1600, 1800, 1850, 2150, 2500, 2800, 3000, 3100, 3150, 3200, 3300, 3350,
        4000, 4900, 5000};
    initial forever #5 pclk = ~pclk;
    lvc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .standby_state(stby), .pwrup_load(load), .pwrup_in_seq(in_seq), .nvm_switch_mode_sel(nvm_sw),
        .nvm_voltage_setpoint(nvm_v), .reg_enable(reg_enable), .reg_pulldown(reg_pulldown),
        .switch_enable(switch_enable), .voltage_setpoint(vset), .voltage_mv(mv));
    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // held until pready is sampled high; bounded so a dead slave ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
            report_and_stop();
        end
        r = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic st(input logic [2:0] e);
        repeat (3) @(posedge pclk);
        chk("en_pd_sw", 32'(e), 32'({reg_enable, reg_pulldown, switch_enable}));
    endtask
    task automatic pulse_load();
        @(posedge pclk) load <= 1;
        @(posedge pclk) load <= 0;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        st(3'b010);
        pulse_load();
        st(3'b100);
        chk("setpoint", 32'h7, 32'(vset));
        apb(0, LVC_OFS_VOLT, 32'h0, rd);
        chk("volt", 32'h77, rd);
        apb(1, LVC_OFS_CTRL, 32'h1, rd);
        stby <= 1;
        st(3'b010);
        apb(1, LVC_OFS_CTRL, 32'h2, rd);
        st(3'b100);
        for (int c = 0; c < 16; c++) begin
            apb(1, LVC_OFS_VOLT, {24'h0, 4'(15 - c), 4'(c)}, rd);
            repeat (3) @(posedge pclk);
            chk("stby_code", 32'(15 - c), 32'(vset));
            chk("mv", mv_tbl[15 - c], 32'(mv));
        end
        stby <= 0;
        st(3'b010);
        chk("run_code", 32'hf, 32'(vset));
        apb(1, LVC_OFS_CTRL, 32'h3, rd);
        st(3'b100);
        nvm_sw <= 1;
        st(3'b001);
        apb(0, LVC_OFS_STAT, 32'h0, rd);
        chk("mode", 32'h2, 32'(rd[9:8]));
        apb(1, LVC_OFS_CTRL, 32'h0, rd);
        st(3'b010);
        apb(0, 12'h010, 32'h0, rd);
        chk("unmapped", 32'h1, 32'(err));
        apb(1, LVC_OFS_CTRL, 32'h3, rd);
        st(3'b001);
        in_seq <= 0;
        pulse_load();
        st(3'b010);
        apb(0, LVC_OFS_CTRL, 32'h0, rd);
        chk("ctrl", 32'h0, rd);
        report_and_stop();
    end
endmodule
